//--- core/blc_lane.sv
// one byte lane: config register, status register, termination and strobe control
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
module blc_lane #(
	parameter int LANE_ID = 0 // lane number, 0 to 8
) (
	input wire logic clk_i, // 10 MHz configuration clock
	input wire logic rst_n_i, // async reset, active low
	input wire logic [3:0] addr_i, // register word address
	input wire logic [31:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [31:0] rdata_o, // read data, cycle after rd_i
	output logic irq_o, // level interrupt
	input wire logic read_active_i, // read window incl. postamble
	input wire logic dqs_clk_i, // write strobe toggle source
	input wire logic dqs_oe_i, // strobe output enable from datapath
	input wire logic [4:0] cal_done_i, // per-measurement done pulses from pin side
	input wire logic wl_done_i, // write leveling done from pin side
	output logic dq_odt_o, // data/mask termination control
	output logic dqs_odt_o, // strobe termination control
	output logic dqs_o, // true strobe output value
	output logic dqs_n_o, // complementary strobe output value
	output logic dqs_oe_n_o, // strobe output enable, low while driving
	output logic read_strobe_pd_o, // read strobe cell power down
	output logic rx_pd_o, // receiver power down
	output logic tx_pd_o, // driver power down
	output logic io_cmos_o, // 1 cmos, 0 sstl
	output logic lane_active_o // lane takes part in training and transfers
);
	initial begin
		if (LANE_ID < 0 || LANE_ID > 8) $error("lane id out of range");
	end

	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [31:0] cfg_r;
	logic [blc_pkg::N_CAL-1:0] cal_flag_r;
	logic [blc_pkg::N_CAL-1:0] cal_prev_r;
	logic [1:0] cal_cnt_r [blc_pkg::N_CAL];
	logic wl_done_r;
	logic wl_rise_r;
	logic [blc_pkg::N_IRQ-1:0] irq_stat_r;
	logic [blc_pkg::N_IRQ-1:0] irq_mask_r;
	logic [1:0] hold_cnt_r;
	logic hold_on_r;
	logic read_d_r;
	logic [2:0] rd_sync_r;
	logic [2:0] dqs_sync_r;
	logic [2:0] oe_sync_r;
	logic [3*blc_pkg::N_CAL-1:0] cal_sync_r;
	logic [2:0] wl_sync_r;
	logic all_done;
	logic term_window;
	logic dqs_val;

	assign rst_n = rst_sync_r[1];

	// release reset through two flops so all fields leave reset on one edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) rst_sync_r <= 2'h0;
		else rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	// pin-side inputs cross three flops; settled only while second and third are both high
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_sync_r <= 3'h0;
			dqs_sync_r <= 3'h0;
			oe_sync_r <= 3'h0;
			wl_sync_r <= 3'h0;
			cal_sync_r <= '0;
		end else begin
			rd_sync_r <= {rd_sync_r[1:0], read_active_i};
			dqs_sync_r <= {dqs_sync_r[1:0], dqs_clk_i};
			oe_sync_r <= {oe_sync_r[1:0], dqs_oe_i};
			wl_sync_r <= {wl_sync_r[1:0], wl_done_i};
			for (int i = 0; i < blc_pkg::N_CAL; i++) begin
				cal_sync_r[3*i +: 3] <= {cal_sync_r[3*i +: 2], cal_done_i[i]};
			end
		end
	end

	function automatic logic settled(input logic [2:0] s);
		settled = s[1] & s[2];
	endfunction

	// config register
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) cfg_r <= blc_pkg::CFG_RESET;
		else if (wr_i && addr_i == blc_pkg::ADDR_CFG) begin
			cfg_r <= wdata_i & blc_pkg::CFG_WMASK;
		end
	end

	// a flag holds its minimum time even if all measurements finish early
	assign all_done = &cal_flag_r;
	generate
		for (genvar g = 0; g < blc_pkg::N_CAL; g++) begin : g_cal
			// set on the rising edge only, so a done level held high cannot re-set the flag
			always_ff @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					cal_flag_r[g] <= 1'b0;
					cal_cnt_r[g] <= 2'h0;
					cal_prev_r[g] <= 1'b0;
				end else begin
					cal_prev_r[g] <= settled(cal_sync_r[3*g +: 3]);
					if (settled(cal_sync_r[3*g +: 3]) && !cal_prev_r[g] && cfg_r[blc_pkg::B_EN]) begin
						cal_flag_r[g] <= 1'b1;
						if (cal_cnt_r[g] != blc_pkg::CAL_MIN_CYC) cal_cnt_r[g] <= cal_cnt_r[g] + 2'h1;
					end else if (cal_flag_r[g] && cal_cnt_r[g] != blc_pkg::CAL_MIN_CYC) begin
						cal_cnt_r[g] <= cal_cnt_r[g] + 2'h1;
					end else if (all_done && cal_cnt_r[g] == blc_pkg::CAL_MIN_CYC) begin
						cal_flag_r[g] <= 1'b0;
						cal_cnt_r[g] <= 2'h0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) wl_done_r <= 1'b0;
		else if (!cfg_r[blc_pkg::B_EN]) wl_done_r <= 1'b0;
		else if (settled(wl_sync_r)) wl_done_r <= 1'b1;
	end

	// one-cycle event when leveling completes; the sticky level alone would re-set the irq
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) wl_rise_r <= 1'b0;
		else wl_rise_r <= cfg_r[blc_pkg::B_EN] & settled(wl_sync_r) & ~wl_done_r;
	end

	// interrupt status: set wins over write-one-to-clear
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) irq_stat_r <= '0;
		else begin
			for (int i = 0; i < blc_pkg::N_IRQ; i++) begin
				logic set_v;
				set_v = (i == blc_pkg::IRQ_CAL) ? all_done : wl_rise_r;
				if (set_v) irq_stat_r[i] <= 1'b1;
				else if (wr_i && addr_i == blc_pkg::ADDR_IRQ_STAT && wdata_i[i]) irq_stat_r[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) irq_mask_r <= '0;
		else if (wr_i && addr_i == blc_pkg::ADDR_IRQ_MASK) irq_mask_r <= wdata_i[blc_pkg::N_IRQ-1:0];
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) irq_o <= 1'b0;
		else irq_o <= |(irq_stat_r & irq_mask_r);
	end

	// read data, unmapped addresses read zero
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) rdata_o <= 32'h0;
		else if (rd_i) begin
			case (addr_i)
				blc_pkg::ADDR_CFG: rdata_o <= cfg_r;
				blc_pkg::ADDR_STAT0: rdata_o <= {26'h0, wl_done_r, cal_flag_r};
				blc_pkg::ADDR_IRQ_STAT: rdata_o <= {30'h0, irq_stat_r};
				blc_pkg::ADDR_IRQ_MASK: rdata_o <= {30'h0, irq_mask_r};
				default: rdata_o <= 32'h0;
			endcase
		end else rdata_o <= 32'h0;
	end

	// termination hold after read postamble
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			read_d_r <= 1'b0;
			hold_cnt_r <= 2'h0;
			hold_on_r <= 1'b0;
		end else begin
			read_d_r <= settled(rd_sync_r);
			if (settled(rd_sync_r)) hold_on_r <= 1'b0;
			else if (read_d_r) begin
				hold_cnt_r <= cfg_r[blc_pkg::B_HOLD_LO +: 2];
				hold_on_r <= cfg_r[blc_pkg::B_HOLD_LO +: 2] != 2'h0;
			end else if (hold_on_r) begin
				hold_cnt_r <= hold_cnt_r - 2'h1;
				hold_on_r <= hold_cnt_r != 2'h1;
			end
		end
	end

	// delayed copy bridges the cycle in which the hold counter loads, so no gap opens
	assign term_window = settled(rd_sync_r) | read_d_r | hold_on_r;

	always_comb begin
		case (cfg_r[blc_pkg::B_WRITE_STROBE_ENABLE_SEL_LO +: 2])
			blc_pkg::WRITE_STROBE_ENABLE_SEL_LOW: dqs_val = 1'b0;
			blc_pkg::WRITE_STROBE_ENABLE_SEL_NORM: dqs_val = dqs_sync_r[2];
			blc_pkg::WRITE_STROBE_ENABLE_SEL_INV: dqs_val = ~dqs_sync_r[2];
			blc_pkg::WRITE_STROBE_ENABLE_SEL_HIGH: dqs_val = 1'b1;
			default: dqs_val = 1'b0;
		endcase
	end

	// pin controls; a disabled lane drops termination and strobe drive
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dq_odt_o <= 1'b0;
			dqs_odt_o <= 1'b0;
			dqs_o <= 1'b0;
			dqs_n_o <= 1'b1;
			dqs_oe_n_o <= 1'b1;
		end else begin
			dq_odt_o <= cfg_r[blc_pkg::B_EN] & cfg_r[blc_pkg::B_DTERM]
				& (~cfg_r[blc_pkg::B_DDYN] | term_window);
			dqs_odt_o <= cfg_r[blc_pkg::B_EN] & cfg_r[blc_pkg::B_STERM]
				& (~cfg_r[blc_pkg::B_SDYN] | term_window);
			dqs_o <= dqs_val;
			dqs_n_o <= ~dqs_val;
			dqs_oe_n_o <= ~(settled(oe_sync_r) & cfg_r[blc_pkg::B_EN]);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			read_strobe_pd_o <= 1'b0;
			rx_pd_o <= 1'b0;
			tx_pd_o <= 1'b0;
			io_cmos_o <= 1'b0;
			lane_active_o <= 1'b0;
		end else begin
			read_strobe_pd_o <= cfg_r[blc_pkg::B_RSPD];
			rx_pd_o <= cfg_r[blc_pkg::B_PDR];
			tx_pd_o <= cfg_r[blc_pkg::B_PDD];
			io_cmos_o <= cfg_r[blc_pkg::B_IOM];
			lane_active_o <= cfg_r[blc_pkg::B_EN];
		end
	end
endmodule // blc_lane

//--- core/blc_pkg.sv
// package for the byte lane configuration and status block
package blc_pkg;
	localparam logic [3:0] ADDR_CFG = 4'h0;
	localparam logic [3:0] ADDR_STAT0 = 4'h1;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
	localparam logic [31:0] CFG_RESET = 32'h0000_0e81;
	localparam logic [31:0] CFG_WMASK = 32'h0000_1fff;
	localparam int B_EN = 0;
	localparam int B_STERM = 1;
	localparam int B_DTERM = 2;
	localparam int B_IOM = 3;
	localparam int B_PDD = 4;
	localparam int B_PDR = 5;
	localparam int B_RSPD = 6;
	localparam int B_WRITE_STROBE_ENABLE_SEL_LO = 7;
	localparam int B_SDYN = 9;
	localparam int B_DDYN = 10;
	localparam int B_HOLD_LO = 11;
	localparam int N_CAL = 5;
	localparam int B_WLDONE = 5;
	localparam logic [1:0] CAL_MIN_CYC = 2'h2;
	localparam logic [1:0] WRITE_STROBE_ENABLE_SEL_LOW = 2'h0;
	localparam logic [1:0] WRITE_STROBE_ENABLE_SEL_NORM = 2'h1;
	localparam logic [1:0] WRITE_STROBE_ENABLE_SEL_INV = 2'h2;
	localparam logic [1:0] WRITE_STROBE_ENABLE_SEL_HIGH = 2'h3;
	localparam int N_IRQ = 2;
	localparam int IRQ_CAL = 0;
	localparam int IRQ_WL = 1;
endpackage

//--- tb/blc_lane_properties.sv
// port-level checker for one byte lane
`timescale 1ns/10ps
module blc_lane_properties (
	input wire logic clk_i, // clock
	input wire logic rst_n_i, // async reset
	input wire logic [3:0] addr_i, // address
	input wire logic [31:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [31:0] rdata_o, // read data
	input wire logic dqs_oe_i, // strobe enable in
	input wire logic dqs_o, // true strobe
	input wire logic dqs_n_o, // complement strobe
	input wire logic dqs_oe_n_o, // strobe drive, low
	input wire logic read_strobe_pd_o, // cell power down
	input wire logic rx_pd_o, // receiver power down
	input wire logic tx_pd_o, // driver power down
	input wire logic io_cmos_o, // pin mode
	input wire logic lane_active_o // lane on
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_strobe_pair_inv: assert property (dqs_n_o == !dqs_o)
		else $error("strobe pair not complementary");
	a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside read slot");
	a_rx_pd_follow: assert property (wr_i && addr_i == 4'h0 |-> ##2 rx_pd_o == $past(wdata_i[5], 2))
		else $error("receiver power down wrong");
	a_tx_pd_follow: assert property (wr_i && addr_i == 4'h0 |-> ##2 tx_pd_o == $past(wdata_i[4], 2))
		else $error("driver power down wrong");
	a_io_mode_follow: assert property (wr_i && addr_i == 4'h0 |-> ##2 io_cmos_o == $past(wdata_i[3], 2))
		else $error("pin mode wrong");
	a_cell_pd_follow: assert property (wr_i && addr_i == 4'h0 |-> ##2 read_strobe_pd_o == $past(wdata_i[6], 2))
		else $error("strobe cell power down wrong");
	a_lane_en_follow: assert property (wr_i && addr_i == 4'h0 |-> ##2 lane_active_o == $past(wdata_i[0], 2))
		else $error("lane enable wrong");
	a_strobe_tri_state: assert property (!dqs_oe_i [*6] |-> dqs_oe_n_o)
		else $error("strobe driven without enable");
endmodule // blc_lane_properties

//--- tb/blc_pin_model.sv
// pin-side model: read window, strobe source, calibration results
`timescale 1ns/10ps
module blc_pin_model (
	input wire logic clk_i, // clock
	input wire logic rd_req_i, // bench asks for a read window
	input wire logic oe_req_i, // bench asks for strobe drive
	input wire logic [4:0] cal_req_i, // calibration results
	input wire logic wl_req_i, // leveling result
	output logic read_active_o, // read window
	output logic dqs_clk_o, // strobe source
	output logic dqs_oe_o, // strobe enable
	output logic [4:0] cal_done_o, // measurement done
	output logic wl_done_o // leveling done
);
	logic [1:0] div_r = 2'h0;
	// free-running divider keeps strobe phase repeatable; gated so it stands still when idle
	always_ff @(posedge clk_i) div_r <= div_r + 2'h1;
	assign dqs_clk_o = div_r[1] & oe_req_i;
	assign dqs_oe_o = oe_req_i;
	assign read_active_o = rd_req_i;
	assign cal_done_o = cal_req_i;
	assign wl_done_o = wl_req_i;
endmodule // blc_pin_model

//--- tb/tb_top.sv
// self-checking bench for one byte lane
`timescale 1ns/10ps
module tb_top;
	logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rq = 0, oq = 0, wq = 0;
	logic [3:0] addr_i = 0;
	logic [4:0] cq = 0, cal_done_i;
	logic [7:0] p, pn;
	logic [31:0] wdata_i = 0, rdata_o, v;
	logic irq_o, read_active_i, dqs_clk_i, dqs_oe_i, wl_done_i, dq_odt_o, dqs_odt_o;
	logic dqs_o, dqs_n_o, dqs_oe_n_o, read_strobe_pd_o, rx_pd_o, tx_pd_o, io_cmos_o, lane_active_o;
	int err_count = 0, samples_checked = 0;
	typedef struct {logic [31:0] cfg; logic [4:0] pins;} blc_row_s;
	blc_row_s rows [5] = '{'{32'h0e81, 5'h01}, '{32'h71, 5'h1d}, '{32'h08, 5'h02},
		'{32'h21, 5'h09}, '{32'h49, 5'h13}};
	initial forever #50 clk_i = ~clk_i;
	blc_pin_model i_pin (.clk_i, .rd_req_i(rq), .oe_req_i(oq), .cal_req_i(cq), .wl_req_i(wq),
		.read_active_o(read_active_i), .dqs_clk_o(dqs_clk_i), .dqs_oe_o(dqs_oe_i),
		.cal_done_o(cal_done_i), .wl_done_o(wl_done_i));
	blc_lane i_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o,
		.read_active_i, .dqs_clk_i, .dqs_oe_i, .cal_done_i, .wl_done_i, .dq_odt_o, .dqs_odt_o,
		.dqs_o, .dqs_n_o, .dqs_oe_n_o, .read_strobe_pd_o, .rx_pd_o, .tx_pd_o, .io_cmos_o,
		.lane_active_o);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge clk_i);
		wr_i <= 0;
	endtask
	task rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1;
		@(posedge clk_i);
		rd_i <= 0;
		@(negedge clk_i);
		d = rdata_o;
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1;
		cyc(4);
		rd_reg(4'h0, v);
		chk(v, 32'h0e81);
		rd_reg(4'h1, v);
		chk(v, 32'h0);
		rd_reg(4'h7, v);
		chk(v, 32'h0);
		wr_reg(4'h0, 32'hffff_ffff);
		rd_reg(4'h0, v);
		chk(v, 32'h1fff);
		$display("reset and map test done");
		foreach (rows[i]) begin
			wr_reg(4'h0, rows[i].cfg);
			cyc(3);
			chk({27'h0, read_strobe_pd_o, rx_pd_o, tx_pd_o, io_cmos_o, lane_active_o},
				{27'h0, rows[i].pins});
		end
		$display("pin table test done");
		wr_reg(4'h0, 32'h1e87);
		cyc(3);
		chk({30'h0, dq_odt_o, dqs_odt_o}, 32'h0);
		@(posedge clk_i) rq <= 1;
		cyc(8);
		chk({30'h0, dq_odt_o, dqs_odt_o}, 32'h3);
		@(posedge clk_i) rq <= 0;
		cyc(6);
		chk({30'h0, dq_odt_o, dqs_odt_o}, 32'h3);
		cyc(6);
		chk({30'h0, dq_odt_o, dqs_odt_o}, 32'h0);
		wr_reg(4'h0, 32'h87);
		cyc(3);
		chk({30'h0, dq_odt_o, dqs_odt_o}, 32'h3);
		$display("termination test done");
		@(posedge clk_i) oq <= 1;
		for (int c = 0; c < 4; c++) begin
			wr_reg(4'h0, 32'h1 | (32'(c) << 7));
			cyc(7);
			repeat (8) begin
				cyc(1);
				p = {p[6:0], dqs_o};
			end
			if (c == 1) pn = p;
			chk({24'h0, p}, c == 0 ? 32'h0 : c == 3 ? 32'hff : {24'h0, c == 2 ? ~pn : pn});
			chk({31'h0, dqs_oe_n_o}, 32'h0);
		end
		chk(32'(pn != 8'h0 && pn != 8'hff), 32'h1);
		@(posedge clk_i) oq <= 0;
		cyc(6);
		chk({31'h0, dqs_oe_n_o}, 32'h1);
		wr_reg(4'h0, 32'h06);
		@(posedge clk_i) oq <= 1;
		cyc(6);
		chk({29'h0, dqs_oe_n_o, dq_odt_o, dqs_odt_o}, 32'h4);
		@(posedge clk_i) oq <= 0;
		$display("strobe and enable test done");
		wr_reg(4'h0, 32'h0e81);
		@(posedge clk_i) cq <= 5'h1f;
		@(posedge clk_i) wq <= 1;
		cyc(10);
		chk({31'h0, irq_o}, 32'h0);
		wr_reg(4'h3, 32'h3);
		cyc(3);
		chk({31'h0, irq_o}, 32'h1);
		rd_reg(4'h2, v);
		chk(v, 32'h3);
		rd_reg(4'h1, v);
		chk(v, 32'h20);
		@(posedge clk_i) cq <= 5'h0;
		@(posedge clk_i) wq <= 0;
		cyc(5);
		wr_reg(4'h2, 32'h3);
		cyc(3);
		chk({31'h0, irq_o}, 32'h0);
		rd_reg(4'h2, v);
		chk(v, 32'h0);
		$display("status and interrupt test done");
		give_verdict;
	end
	initial begin
		#200000;
		err_count++;
		give_verdict;
	end
endmodule // tb_top
bind blc_lane blc_lane_properties u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .dqs_oe_i, .dqs_o, .dqs_n_o, .dqs_oe_n_o, .read_strobe_pd_o, .rx_pd_o,
	.tx_pd_o, .io_cmos_o, .lane_active_o);
